// ---- rtl/dpsc_consts.vh ----
// Constants for the sample-clock synthesizer control block.
// Assumes inclusion by bare name from design files only.
`ifndef DPSC_CONSTS_VH
`define DPSC_CONSTS_VH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define DPSC_ADDR_IRQ_ENABLE 12'h01f
`define DPSC_ADDR_IRQ_STATUS 12'h023
`define DPSC_ADDR_CONTROL 12'h083
`define DPSC_ADDR_STATUS 12'h084
`define DPSC_ADDR_FB_DIV 12'h085
`define DPSC_ADDR_OSC_DIV 12'h08b
`define DPSC_ADDR_REF_DIV 12'h08c
`define DPSC_ADDR_OSC_LEVEL 12'h1b6
`define DPSC_ADDR_OSC_BIAS 12'h1bb
// ----------------------------------------
// Field positions
// ----------------------------------------
`define DPSC_CTL_ENABLE_BIT 4
`define DPSC_CTL_RECAL_BIT 7
`define DPSC_ST_LOCK_BIT 1
`define DPSC_ST_CAL_DONE_BIT 5
`define DPSC_ST_LOW_EDGE_BIT 6
`define DPSC_ST_HIGH_EDGE_BIT 7
`define DPSC_IRQ_LOST_BIT 6
`define DPSC_IRQ_LOCK_BIT 7
// ----------------------------------------
// Reset values and sizes
// ----------------------------------------
`define DPSC_RST_CONTROL 8'h80
`define DPSC_RST_ZERO 8'h00
`define DPSC_BAND_LAST 9'h1ff
`define DPSC_BAND_START 9'h100
// ----------------------------------------
// Timing counts
// ----------------------------------------
`define DPSC_CP_CAL_CYCLES 8'h40
`define DPSC_BAND_SETTLE_CYCLES 8'h10
`define DPSC_LOCK_HOLD_CYCLES 8'h20
`endif

// ---- rtl/dpsc_edge_sync.v ----
// Three-stage synchroniser with agreement filter and edge pulses.
// Assumes an asynchronous level input and one clock.
`timescale 1ns/10ps
module dpsc_edge_sync (
  // Clock and reset
  input wire clk_in,
  input wire nrst_in,
  // Level in and out
  input wire async_in,
  output wire level_out,
  output wire rise_out,
  output wire fall_out
);
  reg s1_reg;
  reg s2_reg;
  reg s3_reg;
  reg level_reg;
  reg prev_reg;
  always @(posedge clk_in) begin
    if (!nrst_in) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      level_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else begin
      s1_reg <= async_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      // Change counts once stages two and three agree
      if (s2_reg == s3_reg) begin
        level_reg <= s3_reg;
      end
      prev_reg <= level_reg;
    end
  end
  assign level_out = level_reg;
  assign rise_out = level_reg & ~prev_reg;
  assign fall_out = ~level_reg & prev_reg;
endmodule // dpsc_edge_sync

// ---- rtl/dpsc_pll_ctrl.v ----
// Control and status for the sample-clock synthesizer: register port,
// start-up sequencing, automatic band search, lock and band-edge status.
// Assumes analog comparators on pins and a single-cycle register port.
//
// Notes on behaviour
// RULE1: Band search picks one of 512 oscillator bands without software help.
// RULE2: Software writes level 0x49 below 8.69 GHz, 0x4d at or above.
// RULE3: Software writes bias 0x15, 0x13 or 0x04 by oscillator frequency.
// RULE4: Software puts oscillator divider code in bits 1:0 of osc_output_divider.
// RULE5: Software puts feedback ratio in all eight bits of feedback_divider.
// RULE6: Software puts reference divider code in bits 2:0 of reference_divider.
// RULE7: Synthesizer starts only when control bit 4 is one, set last.
// RULE8: Status bit 5 rises when calibration finishes with valid result.
// RULE9: Status bit 1 is high while the loop is locked.
// RULE10: Status bit 7 marks upper band edge, bit 6 lower band edge.
// RULE11: Writing control bit 7 zero then one reruns calibration.
// RULE12: Lock and lost-lock interrupts gated by enable bits 7:6.
// RULE13: Interrupt status bits 7:6 show and clear lock events.
// RULE14: Software writes fixed settings before dividers, chosen in advance.
// RULE15: Charge pump calibrates automatically on first enable.
// RULE16: Reference code 1..4 selects divide by 2, 4, 8, 16.
// RULE17: Oscillator code 1..3 selects divide by 4, 8, 16.
// RULE18: Software keeps feedback ratio between 6 and 127.
// RULE19: Lock status sets on rise, lost on fall, held until cleared.
`timescale 1ns/10ps
`include "dpsc_consts.vh"
module dpsc_pll_ctrl (
  // Clock and reset
  input wire clk_in,
  input wire nrst_in,
  // Register port
  input wire [11:0] reg_addr_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  input wire [7:0] reg_wdata_in,
  output wire [7:0] reg_rdata_out,
  output wire reg_ack_out,
  // Analog comparators from the oscillator and detector
  input wire lock_detect_in,
  input wire band_high_in,
  input wire band_low_in,
  input wire tune_above_in,
  // Analog controls
  output wire [8:0] osc_band_out,
  output wire pll_power_out,
  output wire cp_cal_out,
  output wire [7:0] feedback_div_ratio_out,
  output wire [4:0] ref_div_ratio_out,
  output wire [4:0] osc_div_ratio_out,
  output wire [7:0] osc_level_out,
  output wire [7:0] osc_bias_out,
  // Interrupt request, active high
  output wire irq_out
);
  // ----------------------------------------
  // Decoding functions
  // ----------------------------------------
  // Unlisted codes fall back to the smallest ratio
  function [4:0] ref_ratio_of;
    input [2:0] code;
    begin
      case (code)
        3'h1: ref_ratio_of = 5'h02;
        3'h2: ref_ratio_of = 5'h04;
        3'h3: ref_ratio_of = 5'h08;
        3'h4: ref_ratio_of = 5'h10;
        default: ref_ratio_of = 5'h02;
      endcase
    end
  endfunction
  function [4:0] osc_ratio_of;
    input [1:0] code;
    begin
      case (code)
        2'h1: osc_ratio_of = 5'h04;
        2'h2: osc_ratio_of = 5'h08;
        2'h3: osc_ratio_of = 5'h10;
        default: osc_ratio_of = 5'h04;
      endcase
    end
  endfunction
  function hit;
    input [11:0] a;
    input [11:0] b;
    begin
      hit = (a == b);
    end
  endfunction
  // ----------------------------------------
  // State machine codes
  // ----------------------------------------
  localparam ST_IDLE = 3'h0;
  localparam ST_CP_CAL = 3'h1;
  localparam ST_BAND = 3'h2;
  localparam ST_SETTLE = 3'h3;
  localparam ST_LOCK_WAIT = 3'h4;
  localparam ST_RUN = 3'h5;
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg [7:0] irq_enable_reg;
  reg [7:0] irq_status_reg;
  reg [7:0] control_reg;
  reg [7:0] fb_div_reg;
  reg [7:0] osc_div_reg;
  reg [7:0] ref_div_reg;
  reg [7:0] osc_level_reg;
  reg [7:0] osc_bias_reg;
  reg [7:0] rdata_reg;
  reg ack_reg;
  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg [7:0] count_reg;
  reg [7:0] count_next;
  reg [8:0] band_reg;
  reg [8:0] band_next;
  reg [8:0] step_reg;
  reg [8:0] step_next;
  reg cp_done_reg;
  reg cal_done_reg;
  reg cal_done_next;
  reg recal_req_reg;
  wire lock_lvl;
  wire lock_rise;
  wire lock_fall;
  wire high_lvl;
  wire low_lvl;
  wire above_lvl;
  wire enable_bit;
  wire wr_ctl;
  wire wr_irq_status;
  wire [7:0] status_view;
  wire locked;
  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  dpsc_edge_sync u_lock_sync (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .async_in(lock_detect_in),
    .level_out(lock_lvl),
    .rise_out(),
    .fall_out()
  );
  dpsc_edge_sync u_high_sync (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .async_in(band_high_in),
    .level_out(high_lvl),
    .rise_out(),
    .fall_out()
  );
  dpsc_edge_sync u_low_sync (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .async_in(band_low_in),
    .level_out(low_lvl),
    .rise_out(),
    .fall_out()
  );
  dpsc_edge_sync u_above_sync (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .async_in(tune_above_in),
    .level_out(above_lvl),
    .rise_out(),
    .fall_out()
  );
  // ----------------------------------------
  // Lock qualification
  // ----------------------------------------
  // Lock counts only once the search has settled in run state
  reg lock_q_reg;
  assign locked = (state_reg == ST_RUN) & lock_lvl;
  assign lock_rise = locked & ~lock_q_reg;
  assign lock_fall = ~locked & lock_q_reg;
  assign enable_bit = control_reg[`DPSC_CTL_ENABLE_BIT];
  assign wr_ctl = reg_wr_in & hit(reg_addr_in, `DPSC_ADDR_CONTROL);
  assign wr_irq_status = reg_wr_in & hit(reg_addr_in, `DPSC_ADDR_IRQ_STATUS);
  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  // RULE4 RULE5 RULE6: divider fields
  always @(posedge clk_in) begin
    if (!nrst_in) begin
      irq_enable_reg <= `DPSC_RST_ZERO;
      control_reg <= `DPSC_RST_CONTROL;
      fb_div_reg <= `DPSC_RST_ZERO;
      osc_div_reg <= `DPSC_RST_ZERO;
      ref_div_reg <= `DPSC_RST_ZERO;
      osc_level_reg <= `DPSC_RST_ZERO;
      osc_bias_reg <= `DPSC_RST_ZERO;
      recal_req_reg <= 1'b0;
    end else begin
      if (reg_wr_in & hit(reg_addr_in, `DPSC_ADDR_IRQ_ENABLE)) begin
        irq_enable_reg <= reg_wdata_in & 8'hc0;
      end
      if (wr_ctl) begin
        control_reg <= reg_wdata_in & 8'h90;
      end
      if (reg_wr_in & hit(reg_addr_in, `DPSC_ADDR_FB_DIV)) begin
        fb_div_reg <= reg_wdata_in;
      end
      if (reg_wr_in & hit(reg_addr_in, `DPSC_ADDR_OSC_DIV)) begin
        osc_div_reg <= reg_wdata_in & 8'h03;
      end
      if (reg_wr_in & hit(reg_addr_in, `DPSC_ADDR_REF_DIV)) begin
        ref_div_reg <= reg_wdata_in & 8'h07;
      end
      // RULE2 RULE3: tuning words held as written
      if (reg_wr_in & hit(reg_addr_in, `DPSC_ADDR_OSC_LEVEL)) begin
        osc_level_reg <= reg_wdata_in;
      end
      if (reg_wr_in & hit(reg_addr_in, `DPSC_ADDR_OSC_BIAS)) begin
        osc_bias_reg <= reg_wdata_in;
      end
      // RULE11: rising recal bit requests a new search
      if (wr_ctl & reg_wdata_in[`DPSC_CTL_RECAL_BIT] & ~control_reg[`DPSC_CTL_RECAL_BIT]) begin
        recal_req_reg <= 1'b1;
      end else if (state_reg == ST_BAND) begin
        recal_req_reg <= 1'b0;
      end
    end
  end
  // ----------------------------------------
  // Interrupt status
  // ----------------------------------------
  // RULE19 RULE13: set wins over write-one clear
  always @(posedge clk_in) begin
    if (!nrst_in) begin
      irq_status_reg <= `DPSC_RST_ZERO;
      lock_q_reg <= 1'b0;
    end else begin
      lock_q_reg <= locked;
      irq_status_reg[`DPSC_IRQ_LOCK_BIT] <= lock_rise |
        (irq_status_reg[`DPSC_IRQ_LOCK_BIT] & ~(wr_irq_status & reg_wdata_in[`DPSC_IRQ_LOCK_BIT]));
      irq_status_reg[`DPSC_IRQ_LOST_BIT] <= lock_fall |
        (irq_status_reg[`DPSC_IRQ_LOST_BIT] & ~(wr_irq_status & reg_wdata_in[`DPSC_IRQ_LOST_BIT]));
    end
  end
  // RULE12: enable gates each source
  assign irq_out = |(irq_status_reg & irq_enable_reg & 8'hc0);
  // ----------------------------------------
  // Calibration and band search
  // ----------------------------------------
  // Binary search over nine bits; tune_above says the band is too high
  always @* begin
    state_next = state_reg;
    count_next = count_reg;
    band_next = band_reg;
    step_next = step_reg;
    cal_done_next = cal_done_reg;
    case (state_reg)
      // RULE7: nothing starts until enable is set
      ST_IDLE: begin
        cal_done_next = 1'b0;
        if (enable_bit) begin
          count_next = `DPSC_CP_CAL_CYCLES;
          // RULE15: charge pump only on first enable
          state_next = cp_done_reg ? ST_BAND : ST_CP_CAL;
        end
      end
      ST_CP_CAL: begin
        count_next = count_reg - 8'h01;
        if (count_reg == 8'h01) begin
          state_next = ST_BAND;
        end
      end
      // RULE1: search starts mid range
      ST_BAND: begin
        band_next = `DPSC_BAND_START;
        step_next = `DPSC_BAND_START;
        count_next = `DPSC_BAND_SETTLE_CYCLES;
        cal_done_next = 1'b0;
        state_next = ST_SETTLE;
      end
      ST_SETTLE: begin
        count_next = count_reg - 8'h01;
        if (count_reg == 8'h01) begin
          count_next = `DPSC_BAND_SETTLE_CYCLES;
          if (step_reg == 9'h000) begin
            count_next = `DPSC_LOCK_HOLD_CYCLES;
            state_next = ST_LOCK_WAIT;
          end else begin
            step_next = {1'b0, step_reg[8:1]};
            if (above_lvl) begin
              band_next = (band_reg & ~step_reg) | {1'b0, step_reg[8:1]};
            end else begin
              band_next = band_reg | {1'b0, step_reg[8:1]};
            end
          end
        end
      end
      // RULE8: done once the chosen band has settled
      ST_LOCK_WAIT: begin
        count_next = count_reg - 8'h01;
        if (count_reg == 8'h01) begin
          cal_done_next = 1'b1;
          state_next = ST_RUN;
        end
      end
      ST_RUN: begin
        // RULE11: recalibration reruns the search
        if (recal_req_reg) begin
          state_next = ST_BAND;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    if (!enable_bit) begin
      state_next = ST_IDLE;
    end
  end
  always @(posedge clk_in) begin
    if (!nrst_in) begin
      state_reg <= ST_IDLE;
      count_reg <= 8'h00;
      band_reg <= `DPSC_BAND_START;
      step_reg <= 9'h000;
      cal_done_reg <= 1'b0;
      cp_done_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      count_reg <= count_next;
      band_reg <= band_next;
      step_reg <= step_next;
      cal_done_reg <= cal_done_next;
      if (state_reg == ST_CP_CAL && count_reg == 8'h01) begin
        cp_done_reg <= 1'b1;
      end
    end
  end
  // ----------------------------------------
  // Status view and read port
  // ----------------------------------------
  // RULE9 RULE10: live lock and band-edge bits
  assign status_view = {high_lvl & cal_done_reg, low_lvl & cal_done_reg, cal_done_reg, 3'h0, locked, 1'b0};
  always @(posedge clk_in) begin
    if (!nrst_in) begin
      rdata_reg <= 8'h00;
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= reg_rd_in | reg_wr_in;
      if (reg_rd_in) begin
        case (reg_addr_in)
          `DPSC_ADDR_IRQ_ENABLE: rdata_reg <= irq_enable_reg;
          `DPSC_ADDR_IRQ_STATUS: rdata_reg <= irq_status_reg;
          `DPSC_ADDR_CONTROL: rdata_reg <= control_reg;
          `DPSC_ADDR_STATUS: rdata_reg <= status_view;
          `DPSC_ADDR_FB_DIV: rdata_reg <= fb_div_reg;
          `DPSC_ADDR_OSC_DIV: rdata_reg <= osc_div_reg;
          `DPSC_ADDR_REF_DIV: rdata_reg <= ref_div_reg;
          `DPSC_ADDR_OSC_LEVEL: rdata_reg <= osc_level_reg;
          `DPSC_ADDR_OSC_BIAS: rdata_reg <= osc_bias_reg;
          default: rdata_reg <= 8'h00;
        endcase
      end
    end
  end
  assign reg_rdata_out = rdata_reg;
  assign reg_ack_out = ack_reg;
  // ----------------------------------------
  // Analog controls
  // ----------------------------------------
  assign osc_band_out = band_reg;
  assign pll_power_out = enable_bit;
  assign cp_cal_out = (state_reg == ST_CP_CAL);
  assign feedback_div_ratio_out = fb_div_reg;
  // RULE16: reference ratio decode
  assign ref_div_ratio_out = ref_ratio_of(ref_div_reg[2:0]);
  // RULE17: oscillator ratio decode
  assign osc_div_ratio_out = osc_ratio_of(osc_div_reg[1:0]);
  assign osc_level_out = osc_level_reg;
  assign osc_bias_out = osc_bias_reg;
endmodule // dpsc_pll_ctrl

// ---- verif/dac_pll_startup_control_tb_top.sv ----
// Self-checking bench for the synthesizer control block.
// Assumes the bound checker and the band counts of the design header.
`timescale 1ns/10ps
module dac_pll_startup_control_tb_top;
  reg clk_in = 1'b0;
  reg nrst_in = 1'b0;
  reg [11:0] reg_addr_in = 12'h000;
  reg reg_wr_in = 1'b0;
  reg reg_rd_in = 1'b0;
  reg [7:0] reg_wdata_in = 8'h00;
  reg lock_detect_in = 1'b0;
  reg band_high_in = 1'b0;
  reg band_low_in = 1'b0;
  reg tune_above_in = 1'b0;
  wire [7:0] reg_rdata_out, feedback_div_ratio_out, osc_level_out, osc_bias_out;
  wire reg_ack_out, pll_power_out, cp_cal_out, irq_out;
  wire [8:0] osc_band_out;
  wire [4:0] ref_div_ratio_out, osc_div_ratio_out;
  int mismatches = 0;
  int tests_run = 0;
  int cyc = 0;
  dpsc_pll_ctrl dut_u (.clk_in(clk_in), .nrst_in(nrst_in), .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out), .reg_ack_out(reg_ack_out),
    .lock_detect_in(lock_detect_in), .band_high_in(band_high_in), .band_low_in(band_low_in),
    .tune_above_in(tune_above_in), .osc_band_out(osc_band_out), .pll_power_out(pll_power_out),
    .cp_cal_out(cp_cal_out), .feedback_div_ratio_out(feedback_div_ratio_out), .ref_div_ratio_out(ref_div_ratio_out),
    .osc_div_ratio_out(osc_div_ratio_out), .osc_level_out(osc_level_out), .osc_bias_out(osc_bias_out),
    .irq_out(irq_out));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
    @(posedge clk_in);
  endtask
  // Bounded wait on the ack, so a dead port cannot hang the run
  task automatic rc(input logic [11:0] a, input logic [7:0] exp);
    int n;
    @(posedge clk_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (reg_ack_out !== 1'b1 && n < 4);
    // Ack rides in the top bit so a dead port is caught with the data
    chk({reg_ack_out, reg_rdata_out}, {1'b1, exp});
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs;
    logic [11:0] ad[9] = '{12'h01f, 12'h083, 12'h085, 12'h08b, 12'h08c, 12'h1b6, 12'h1bb, 12'h084, 12'h100};
    logic [7:0] wv[9] = '{8'hff, 8'h6f, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff};
    logic [7:0] ex[9] = '{8'hc0, 8'h00, 8'hff, 8'h03, 8'h07, 8'hff, 8'hff, 8'h00, 8'h00};
    rc(12'h083, 8'h80);
    rc(12'h023, 8'h00);
    chk(osc_band_out, 9'h100);
    chk(ref_div_ratio_out, 9'h002);
    chk(osc_div_ratio_out, 9'h004);
    for (int i = 0; i < 9; i++) begin
      wr(ad[i], wv[i]);
      rc(ad[i], ex[i]);
    end
    wr(12'h083, 8'h80);
  endtask
  task automatic t_decode;
    logic [4:0] rx[8] = '{5'h02, 5'h02, 5'h04, 5'h08, 5'h10, 5'h02, 5'h02, 5'h02};
    logic [4:0] ox[4] = '{5'h04, 5'h04, 5'h08, 5'h10};
    for (int i = 0; i < 8; i++) begin
      wr(12'h08c, 8'(i));
      idle(2);
      chk(ref_div_ratio_out, rx[i]);
      if (i < 4) begin
        wr(12'h08b, 8'(i));
        idle(2);
        chk(osc_div_ratio_out, ox[i]);
      end
    end
    wr(12'h085, 8'h7f);
    wr(12'h1b6, 8'h49);
    wr(12'h1bb, 8'h15);
    idle(2);
    chk(feedback_div_ratio_out, 9'h07f);
    chk(osc_level_out, 9'h049);
    chk(osc_bias_out, 9'h015);
  endtask
  task automatic t_start;
    wr(12'h08b, 8'h02);
    wr(12'h085, 8'h10);
    wr(12'h08c, 8'h03);
    wr(12'h1b6, 8'h4d);
    wr(12'h1bb, 8'h04);
    chk(pll_power_out, 9'h0);
    chk({4'h0, osc_div_ratio_out}, 9'h008);
    chk({4'h0, ref_div_ratio_out}, 9'h008);
    chk({osc_level_out, 1'b0}, 9'h09a);
    wr(12'h083, 8'h90);
    idle(3);
    chk(cp_cal_out, 9'h1);
    idle(300);
    rc(12'h084, 8'h20);
    chk(osc_band_out, 9'h1ff);
    lock_detect_in <= 1'b1;
    idle(10);
    rc(12'h084, 8'h22);
    chk(irq_out, 9'h1);
    rc(12'h023, 8'h80);
    wr(12'h023, 8'h80);
    rc(12'h023, 8'h00);
    band_high_in <= 1'b1;
    idle(10);
    rc(12'h084, 8'ha2);
    band_high_in <= 1'b0;
    band_low_in <= 1'b1;
    idle(10);
    rc(12'h084, 8'h62);
    band_low_in <= 1'b0;
  endtask
  task automatic t_recal;
    wr(12'h083, 8'h10);
    wr(12'h083, 8'h90);
    idle(3);
    chk(cp_cal_out, 9'h0);
    rc(12'h084, 8'h00);
    rc(12'h023, 8'h40);
    idle(300);
    rc(12'h084, 8'h22);
    rc(12'h023, 8'hc0);
    wr(12'h01f, 8'h00);
    chk(irq_out, 9'h0);
    // Clear with enables on, so the clear itself must drop the request
    wr(12'h01f, 8'hc0);
    chk(irq_out, 9'h1);
    wr(12'h023, 8'hc0);
    chk(irq_out, 9'h0);
    rc(12'h023, 8'h00);
  endtask
  task automatic t_restart;
    lock_detect_in <= 1'b0;
    tune_above_in <= 1'b1;
    wr(12'h083, 8'h80);
    idle(2);
    chk(pll_power_out, 9'h0);
    rc(12'h084, 8'h00);
    wr(12'h083, 8'h90);
    idle(3);
    chk(cp_cal_out, 9'h0);
    idle(300);
    chk(osc_band_out, 9'h000);
    rc(12'h084, 8'h20);
  endtask
  // ----------------------------------------
  // Run control
  // ----------------------------------------
  task automatic results;
    $display("Checks run %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    forever #10 clk_in = ~clk_in;
  end
  // Whole run is near 1160 cycles; the ceiling leaves ample slack
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 6000) begin
      mismatches++;
      results();
    end
  end
  initial begin
    repeat (6) @(posedge clk_in);
    nrst_in <= 1'b1;
    t_regs();
    t_decode();
    t_start();
    t_recal();
    t_restart();
    results();
  end
endmodule // dac_pll_startup_control_tb_top

// ---- verif/dpsc_pll_ctrl_assertions.sv ----
// Port-level checker for the synthesizer control block.
// Assumes binding to dpsc_pll_ctrl; sees only its ports.
`timescale 1ns/10ps
module dpsc_pll_ctrl_assertions (
  // Clock and reset
  input wire clk_in,
  input wire nrst_in,
  // Register port
  input wire [11:0] reg_addr_in,
  input wire reg_wr_in,
  input wire [7:0] reg_wdata_in,
  // Pins and controls
  input wire lock_detect_in,
  input wire pll_power_out,
  input wire cp_cal_out,
  input wire [7:0] feedback_div_ratio_out,
  input wire [4:0] ref_div_ratio_out,
  input wire [4:0] osc_div_ratio_out,
  input wire irq_out
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  wire en_wr = reg_wr_in && reg_addr_in == 12'h083 && reg_wdata_in[4];
  wire ctl_wr = reg_wr_in && reg_addr_in == 12'h083;
  wire fb_wr = reg_wr_in && reg_addr_in == 12'h085;
  reg [3:0] quiet_reg;
  reg lock_q_reg;
  // Lock events land cycles after a pin or mode change, so clears are judged only when quiet
  always @(posedge clk_in) begin
    lock_q_reg <= lock_detect_in;
    if (!nrst_in || ctl_wr || lock_q_reg != lock_detect_in)
      quiet_reg <= 4'h0;
    else if (quiet_reg != 4'hf)
      quiet_reg <= quiet_reg + 4'h1;
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  sequence s_cal_run;
    cp_cal_out [*8];
  endsequence
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  a_power_needs_enable: assert property ($rose(pll_power_out) |-> $past(en_wr) || $past(en_wr, 2))
    else $error("power rose without enable write");
  a_cal_while_powered: assert property (cp_cal_out |-> pll_power_out || $past(pll_power_out))
    else $error("charge pump cal without power");
  a_cal_min_length: assert property ($rose(cp_cal_out) |=> s_cal_run)
    else $error("charge pump cal too short");
  a_ref_div_eight: assert property (reg_wr_in && reg_addr_in == 12'h08c && reg_wdata_in[2:0] == 3'h3
    |-> ##[1:2] ref_div_ratio_out == 5'h08) else $error("reference code 3 not divide by 8");
  a_ref_div_default: assert property (reg_wr_in && reg_addr_in == 12'h08c && reg_wdata_in[2:0] == 3'h6
    |-> ##[1:2] ref_div_ratio_out == 5'h02) else $error("reference code 6 not divide by 2");
  a_osc_div_sixteen: assert property (reg_wr_in && reg_addr_in == 12'h08b && reg_wdata_in[1:0] == 2'h3
    |-> ##[1:2] osc_div_ratio_out == 5'h10) else $error("oscillator code 3 not divide by 16");
  a_fb_div_source: assert property (!$stable(feedback_div_ratio_out) |-> $past(fb_wr) || $past(fb_wr, 2))
    else $error("feedback ratio moved without write");
  a_irq_gate_off: assert property (reg_wr_in && reg_addr_in == 12'h01f && reg_wdata_in[7:6] == 2'h0
    |-> ##[1:2] !irq_out) else $error("interrupt with enables off");
  a_irq_clear_works: assert property (reg_wr_in && reg_addr_in == 12'h023 && reg_wdata_in[7:6] == 2'h3
    && quiet_reg >= 4'ha |-> ##[1:2] !irq_out) else $error("interrupt not cleared");
endmodule // dpsc_pll_ctrl_assertions

bind dpsc_pll_ctrl dpsc_pll_ctrl_assertions chk_u (.clk_in(clk_in), .nrst_in(nrst_in), .reg_addr_in(reg_addr_in),
  .reg_wr_in(reg_wr_in), .reg_wdata_in(reg_wdata_in), .lock_detect_in(lock_detect_in), .pll_power_out(pll_power_out),
  .cp_cal_out(cp_cal_out), .feedback_div_ratio_out(feedback_div_ratio_out), .ref_div_ratio_out(ref_div_ratio_out),
  .osc_div_ratio_out(osc_div_ratio_out), .irq_out(irq_out));
